//--- hdl/iolc_defs.svh
// register offsets, widths and reset values of the i/o line controller
`ifndef IOLC_DEFS_SVH
`define IOLC_DEFS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define IOLC_LINES       32
`define IOLC_AW          8

// ----------------------------------------
// byte offsets
// ----------------------------------------
`define IOLC_OFS_CODR    8'h34
`define IOLC_OFS_ODSR    8'h38
`define IOLC_OFS_PDSR    8'h3c
`define IOLC_OFS_IER     8'h40
`define IOLC_OFS_IDR     8'h44
`define IOLC_OFS_IMR     8'h48
`define IOLC_OFS_ISR     8'h4c
`define IOLC_OFS_MDER    8'h50
`define IOLC_OFS_MDDR    8'h54
`define IOLC_OFS_MDSR    8'h58
`define IOLC_OFS_PUDR    8'h60
`define IOLC_OFS_PUER    8'h64
`define IOLC_OFS_PUSR    8'h68
`define IOLC_OFS_ASR     8'h70
`define IOLC_OFS_BSR     8'h74
`define IOLC_OFS_ABSR    8'h78
`define IOLC_OFS_OWSR    8'ha8

// ----------------------------------------
// reset values
// ----------------------------------------
`define IOLC_RST_ZERO    32'h0000_0000

`endif

//--- hdl/iolc_pkg.sv
// types shared by the i/o line controller files
package iolc_pkg;
  typedef logic [31:0] iolc_word_t;
  typedef enum logic [1:0] {IOLC_IDLE, IOLC_ACK} iolc_bus_e;
endpackage : iolc_pkg

//--- hdl/iolc_sync.sv
// three-stage pin synchroniser with second/third agreement
`timescale 1ns/1ps
module iolc_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------
  // stages
  // ----------------------------------------
  // first stage is read only by the second one
  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // ----------------------------------------
  // agreed level
  // ----------------------------------------
  // level follows the pin even through reset; no constant reset value
  always_ff @(posedge clk_i)
  begin
    if (ce_i && (s2_r == s3_r))
    begin
      q_o <= s3_r;
    end
  end
endmodule : iolc_sync

//--- hdl/iolc_pad.sv
// one pad driver: push-pull or open-drain output stage
`timescale 1ns/1ps
module iolc_pad
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic val_i,
  input  wire logic drive_i,
  input  wire logic odrain_i,
  output logic      out_o,
  output logic      oe_o
);
  // ----------------------------------------
  // output stage
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_o <= 1'b0;
      oe_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      // open drain only pulls low, releases for high
      out_o <= odrain_i ? 1'b0 : val_i;
      oe_o  <= drive_i & (~odrain_i | ~val_i);
    end
  end
endmodule : iolc_pad

//--- hdl/iolc_top.sv
// i/o line controller: output data, pin status, change irq, drive mode
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "iolc_defs.svh"
module iolc_top
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [31:0] pin_i,
  output logic      [31:0] pin_o,
  output logic      [31:0] pin_oe_o,
  input  wire logic [31:0] line_drive_en_i,
  input  wire logic [31:0] line_write_perm_i,
  input  wire logic [31:0] set_output_data_i,
  output logic      [31:0] pullup_en_o,
  output logic      [31:0] func_b_sel_o,
  output logic      [31:0] change_irq_o
);
  iolc_pkg::iolc_word_t output_data_status_r;
  iolc_pkg::iolc_word_t change_irq_mask_r;
  iolc_pkg::iolc_word_t change_irq_status_r;
  iolc_pkg::iolc_word_t open_drain_status_r;
  iolc_pkg::iolc_word_t pullup_off_r;
  iolc_pkg::iolc_word_t func_b_r;
  iolc_pkg::iolc_word_t pin_level;
  iolc_pkg::iolc_word_t pin_prev_r;
  iolc_pkg::iolc_word_t pin_change;
  iolc_pkg::iolc_word_t wmask;
  iolc_pkg::iolc_word_t wdata;
  iolc_pkg::iolc_word_t rd_nxt;
  iolc_pkg::iolc_word_t ods_set;
  iolc_pkg::iolc_word_t ods_wen;
  iolc_pkg::iolc_bus_e  bus_r;
  logic                 req;
  logic                 wr_go;
  logic                 rd_go;
  logic                 hit;
  logic                 irq_any;

  // ----------------------------------------
  // per-line synchroniser and pad
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `IOLC_LINES; g = g + 1)
    begin : g_line
      iolc_sync u_sync
      (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   (pin_i[g]),
        .q_o   (pin_level[g])
      );
      iolc_pad u_pad
      (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .ce_i     (ce_i),
        .val_i    (output_data_status_r[g]),
        .drive_i  (line_drive_en_i[g]),
        .odrain_i (open_drain_status_r[g]),
        .out_o    (pin_o[g]),
        .oe_o     (pin_oe_o[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  // one wait state: ack one cycle after request, then dropped
  // reads load data with ack; writes land at the edge the master sees ack
  assign req   = wb_cyc_i & wb_stb_i & (bus_r == iolc_pkg::IOLC_IDLE);
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ce_i & wb_ack_o
               & (bus_r == iolc_pkg::IOLC_ACK);
  assign rd_go = req & ~wb_we_i & ce_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i & wmask;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_r    <= iolc_pkg::IOLC_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      case (bus_r)
        iolc_pkg::IOLC_IDLE:
        begin
          if (wb_cyc_i && wb_stb_i)
          begin
            bus_r    <= iolc_pkg::IOLC_ACK;
            wb_ack_o <= hit;
            wb_err_o <= ~hit;
          end
        end
        default:
        begin
          bus_r    <= iolc_pkg::IOLC_IDLE;
          wb_ack_o <= 1'b0;
          wb_err_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb
  begin
    hit    = 1'b1;
    rd_nxt = `IOLC_RST_ZERO;
    case (wb_adr_i)
      `IOLC_OFS_ODSR: rd_nxt = output_data_status_r;
      `IOLC_OFS_PDSR: rd_nxt = pin_level;
      `IOLC_OFS_IMR:  rd_nxt = change_irq_mask_r;
      `IOLC_OFS_ISR:  rd_nxt = change_irq_status_r;
      `IOLC_OFS_MDSR: rd_nxt = open_drain_status_r;
      `IOLC_OFS_PUSR: rd_nxt = pullup_off_r;
      `IOLC_OFS_ABSR: rd_nxt = func_b_r;
      `IOLC_OFS_OWSR: rd_nxt = line_write_perm_i;
      `IOLC_OFS_CODR, `IOLC_OFS_IER, `IOLC_OFS_IDR, `IOLC_OFS_MDER,
      `IOLC_OFS_MDDR, `IOLC_OFS_PUDR, `IOLC_OFS_PUER, `IOLC_OFS_ASR,
      `IOLC_OFS_BSR:  rd_nxt = `IOLC_RST_ZERO;
      default:        hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= `IOLC_RST_ZERO;
    end
    // held until the next read; writes leave it alone
    else if (rd_go)
    begin
      wb_dat_o <= rd_nxt;
    end
  end

  // ----------------------------------------
  // output data
  // ----------------------------------------
  // set and clear from the same cycle: clear wins, a later write re-sets
  // a set from the neighbouring logic is never lost on untouched lines
  assign ods_set = output_data_status_r | set_output_data_i;
  assign ods_wen = line_write_perm_i & wmask;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      output_data_status_r <= `IOLC_RST_ZERO;
    end
    else if (ce_i)
    begin
      if (wr_go && wb_adr_i == `IOLC_OFS_ODSR)
      begin
        output_data_status_r <= (ods_set & ~ods_wen)
                              | (wb_dat_i & ods_wen);
      end
      else if (wr_go && wb_adr_i == `IOLC_OFS_CODR)
      begin
        output_data_status_r <= ods_set & ~wdata;
      end
      else
      begin
        output_data_status_r <= ods_set;
      end
    end
  end

  // ----------------------------------------
  // irq mask
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      change_irq_mask_r <= `IOLC_RST_ZERO;
    end
    else if (wr_go && wb_adr_i == `IOLC_OFS_IER)
    begin
      change_irq_mask_r <= change_irq_mask_r | wdata;
    end
    else if (wr_go && wb_adr_i == `IOLC_OFS_IDR)
    begin
      change_irq_mask_r <= change_irq_mask_r & ~wdata;
    end
  end

  // ----------------------------------------
  // change detection
  // ----------------------------------------
  // no false change after reset: the sampler and its copy keep running through reset
  assign pin_change = pin_level ^ pin_prev_r;

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      // no reset: it tracks the sampler, which settles inside the reset hold
      pin_prev_r <= pin_level;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      change_irq_status_r <= `IOLC_RST_ZERO;
    end
    else if (ce_i)
    begin
      // a change in the reading cycle survives the clear
      if (rd_go && wb_adr_i == `IOLC_OFS_ISR)
      begin
        change_irq_status_r <= pin_change;
      end
      else
      begin
        change_irq_status_r <= change_irq_status_r | pin_change;
      end
    end
  end

  // only enabled lines reach the interrupt; status still records all lines
  assign irq_any = |(change_irq_status_r & change_irq_mask_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      change_irq_o <= `IOLC_RST_ZERO;
    end
    else if (ce_i)
    begin
      change_irq_o <= {31'h0000_0000, irq_any};
    end
  end

  // ----------------------------------------
  // open drain
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      open_drain_status_r <= `IOLC_RST_ZERO;
    end
    // each pad reads this to choose low-only drive
    else if (wr_go && wb_adr_i == `IOLC_OFS_MDER)
    begin
      open_drain_status_r <= open_drain_status_r | wdata;
    end
    else if (wr_go && wb_adr_i == `IOLC_OFS_MDDR)
    begin
      open_drain_status_r <= open_drain_status_r & ~wdata;
    end
  end

  // ----------------------------------------
  // pull-up
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pullup_off_r <= `IOLC_RST_ZERO;
      pullup_en_o  <= ~`IOLC_RST_ZERO;
    end
    // pad control kept as its own flop so the output stays registered
    else if (wr_go && wb_adr_i == `IOLC_OFS_PUDR)
    begin
      pullup_off_r <= pullup_off_r | wdata;
      pullup_en_o  <= ~(pullup_off_r | wdata);
    end
    else if (wr_go && wb_adr_i == `IOLC_OFS_PUER)
    begin
      pullup_off_r <= pullup_off_r & ~wdata;
      pullup_en_o  <= ~(pullup_off_r & ~wdata);
    end
  end

  // ----------------------------------------
  // peripheral function select
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      func_b_r     <= `IOLC_RST_ZERO;
      func_b_sel_o <= `IOLC_RST_ZERO;
    end
    // status and select output kept equal; both change only on a write
    else if (wr_go && wb_adr_i == `IOLC_OFS_ASR)
    begin
      func_b_r     <= func_b_r & ~wdata;
      func_b_sel_o <= func_b_r & ~wdata;
    end
    else if (wr_go && wb_adr_i == `IOLC_OFS_BSR)
    begin
      func_b_r     <= func_b_r | wdata;
      func_b_sel_o <= func_b_r | wdata;
    end
  end
endmodule : iolc_top

//--- dv/iolc_pads.sv
// pad model: resolves each line from device, outside driver and pull-up
`timescale 1ns/1ps
module iolc_pads
(
  input  wire logic        clk_i,
  input  wire logic [31:0] out_i,
  input  wire logic [31:0] oe_i,
  input  wire logic [31:0] pu_i,
  input  wire logic [31:0] ext_i,
  input  wire logic [31:0] ext_en_i,
  output logic      [31:0] lvl_o
);
  // ----------------------------------------
  // wired-and line: any low driver wins
  // ----------------------------------------
  logic [31:0] lo;
  logic [31:0] last_r;
  assign lo = (oe_i & ~out_i) | (ext_en_i & ~ext_i);
  // a floating line flips every cycle, so a stale level is never trusted
  assign lvl_o = ~lo & ((oe_i & out_i) | (ext_en_i & ext_i) | pu_i | ~last_r);
  always_ff @(posedge clk_i)
    last_r <= lvl_o;
endmodule : iolc_pads

//--- dv/iolc_sva.sv
// bus answer and reset checker of the i/o line controller
`timescale 1ns/1ps
module iolc_sva
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [31:0] pullup_en_o,
  input wire logic [31:0] change_irq_o
);
  // ----------------------------------------
  // bus answers and reset state
  // ----------------------------------------
  logic req;
  assign req = wb_cyc_i && wb_stb_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_next_a: assert property
    (req && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o)
    else $error("request not answered");
  idle_quiet_a: assert property (!req |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  one_answer_a: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  // offsets below the first register belong to neighbouring blocks
  err_low_a: assert property
    (req && wb_adr_i < 8'h34 && !wb_ack_o && !wb_err_o |=> wb_err_o)
    else $error("unmapped access not refused");
  dat_hold_a: assert property (!(req && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data moved");
  irq_upper_a: assert property (change_irq_o[31:1] == 31'h0)
    else $error("upper irq bits set");
  rst_pullup_a: assert property
    (@(posedge clk_i) disable iff (1'h0) rst_i |=> pullup_en_o == 32'hffffffff && !wb_ack_o)
    else $error("reset state wrong");
endmodule : iolc_sva
bind iolc_top iolc_sva SVA
(
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .wb_err_o, .pullup_en_o, .change_irq_o
);

//--- dv/tb_top.sv
// self-checking bench of the i/o line controller
`timescale 1ns/1ps
`include "iolc_defs.svh"
module tb_top;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        cyc   = 1'h0;
  logic        we    = 1'h0;
  logic [7:0]  adr   = 8'h0;
  logic [31:0] wd    = 32'h0;
  logic [31:0] perm  = 32'h0;
  logic [31:0] setd  = 32'h0;
  logic [31:0] drv   = 32'h0;
  logic [31:0] xv    = 32'h0;
  logic [31:0] xe    = 32'hffffffff;
  logic [31:0] rd, q, pin, po, poe, pu, fb, irq;
  logic        ack, err, e_seen;
  int          failures = 0;
  int          n_tests  = 0;
  always #2.5 clk_i = ~clk_i;
  iolc_top DUT
  (
    .clk_i, .rst_i, .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .wb_err_o(err), .pin_i(pin), .pin_o(po), .pin_oe_o(poe), .line_drive_en_i(drv),
    .line_write_perm_i(perm), .set_output_data_i(setd), .pullup_en_o(pu),
    .func_b_sel_o(fb), .change_irq_o(irq)
  );
  iolc_pads PADS
  (
    .clk_i, .out_i(po), .oe_i(poe), .pu_i(pu), .ext_i(xv), .ext_en_i(xe), .lvl_o(pin)
  );
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    {cyc, we, adr, wd} <= {1'h1, w, a, d};
    for (i = 0; i < 20 && !(ack | err); i++)
      @(posedge clk_i);
    q = rd;
    e_seen = err;
    cyc <= 1'h0;
    @(posedge clk_i);
    if (i >= 20)
    begin
      failures++;
      test_done();
    end
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  task automatic t_cfg;
    wb(1'h1, `IOLC_OFS_PUDR, 32'hff);
    rdc(`IOLC_OFS_PUSR, 32'hff);
    chk(pu, 32'hffffff00);
    wb(1'h1, `IOLC_OFS_PUER, 32'hf);
    rdc(`IOLC_OFS_PUSR, 32'hf0);
    wb(1'h1, `IOLC_OFS_MDER, 32'hf);
    wb(1'h1, `IOLC_OFS_MDDR, 32'h3);
    rdc(`IOLC_OFS_MDSR, 32'hc);
    wb(1'h1, `IOLC_OFS_IER, 32'hff00ff00);
    wb(1'h1, `IOLC_OFS_IDR, 32'h0f000f00);
    wb(1'h1, `IOLC_OFS_IMR, 32'hffffffff);
    rdc(`IOLC_OFS_IMR, 32'hf000f000);
    wb(1'h1, `IOLC_OFS_BSR, 32'hff);
    wb(1'h1, `IOLC_OFS_ASR, 32'hf);
    chk(fb, 32'hf0);
  endtask : t_cfg
  task automatic t_change;
    wb(1'h0, `IOLC_OFS_ISR, 32'h0);
    // top lines released: only their pull-ups hold them high
    {xe, xv} <= {32'h00ffffff, 32'h5a5a};
    repeat (8) @(posedge clk_i);
    rdc(`IOLC_OFS_PDSR, 32'hff005a5a);
    chk(irq, 32'h1);
    rdc(`IOLC_OFS_ISR, 32'hff005a5a);
    rdc(`IOLC_OFS_ISR, 32'h0);
    chk(irq, 32'h0);
    {xe, xv} <= {32'hffffffff, 32'h0};
  endtask : t_change
  task automatic t_out;
    perm <= 32'hffff;
    wb(1'h1, `IOLC_OFS_ODSR, 32'hffffffff);
    rdc(`IOLC_OFS_ODSR, 32'hffff);
    wb(1'h1, `IOLC_OFS_CODR, 32'hf00);
    setd <= 32'h10000;
    @(posedge clk_i);
    setd <= 32'h0;
    rdc(`IOLC_OFS_ODSR, 32'h1f0ff);
    wb(1'h1, `IOLC_OFS_CODR, 32'h4);
    {drv, xe} <= {32'hff0c, 32'hffff00ff};
    repeat (8) @(posedge clk_i);
    chk(po & 32'hff00, 32'hf000);
    chk(poe & 32'hff0c, 32'hff04);
    chk(po & 32'hc, 32'h0);
    wb(1'h0, `IOLC_OFS_PDSR, 32'h0);
    chk(q & 32'hff00, 32'hf000);
    {drv, xe} <= {32'h0, 32'hffffffff};
  endtask : t_out
  task automatic t_refuse;
    wb(1'h0, 8'h0, 32'h0);
    chk({31'h0, e_seen}, 32'h1);
    rdc(`IOLC_OFS_IER, 32'h0);
  endtask : t_refuse
  task automatic t_rerst;
    xv <= 32'h1;
    repeat (8) @(posedge clk_i);
    {rst_i, xv} <= {1'h1, 32'h0};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    rdc(`IOLC_OFS_ISR, 32'h0);
    rdc(`IOLC_OFS_PDSR, 32'h0);
    rdc(`IOLC_OFS_PUSR, 32'h0);
    chk(pu, 32'hffffffff);
  endtask : t_rerst
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    t_cfg();
    t_change();
    t_out();
    t_refuse();
    t_rerst();
    test_done();
  end
endmodule : tb_top
